/* hdl/etcu_pkg.sv */
// etcu_pkg: register map, field positions, modes and timing counts of the event timer counter
package etcu_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_HZ          = 10_000_000;
    localparam int CLK_NS          = 100;
    localparam int TRIG_DELAY_US   = 200;
    localparam int TRIG_WIDTH_NS   = 12_800;
    localparam int REC_DELAY_NS    = 450;
    localparam int TRIG_DELAY_CYC  = (TRIG_DELAY_US * 1000) / CLK_NS;
    localparam int TRIG_WIDTH_CYC  = (TRIG_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int REC_DELAY_CYC   = REC_DELAY_NS / CLK_NS;
    localparam int NUM_EVENTS      = 16;
    localparam int NUM_CNT         = 2;
    localparam int DEG_FULL        = 360;
    localparam int RPM_SECONDS     = 60;
    localparam int TBASE_HZ        = 20_000_000;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] REG_EVT_INV   = 8'h00;
    localparam logic [7:0] REG_EVT_STAT  = 8'h04;
    localparam logic [7:0] REG_OUT_CTRL  = 8'h08;
    localparam logic [7:0] REG_CMD       = 8'h0c;
    localparam logic [7:0] REG_CH0_CFG   = 8'h10;
    localparam logic [7:0] REG_CH0_WIN   = 8'h14;
    localparam logic [7:0] REG_CH0_MAX   = 8'h18;
    localparam logic [7:0] REG_CH0_REF   = 8'h1c;
    localparam logic [7:0] REG_CH0_CNT   = 8'h20;
    localparam logic [7:0] REG_CH0_DCNT  = 8'h24;
    localparam logic [7:0] REG_CH0_DT    = 8'h28;
    localparam logic [7:0] CH_STRIDE     = 8'h20;

    // ************************************************************
    // channel config fields
    // ************************************************************
    localparam int CFG_COUPLE_LSB = 0;   // 2 bits
    localparam int CFG_MEAS_LSB   = 2;   // 2 bits
    localparam int CFG_RPOL_LSB   = 4;   // 2 bits reset policy
    localparam int CFG_RINV_BIT   = 6;
    localparam int CFG_FILT_LSB   = 8;   // 8 bits filter length
    localparam int CFG_SIG_LSB    = 16;  // 4 bits pin select
    localparam int CFG_RST_LSB    = 20;
    localparam int CFG_DIR_LSB    = 24;
    localparam int CMD_CLR0_BIT   = 0;
    localparam int CMD_CLR1_BIT   = 1;

    typedef enum logic [1:0] {
        CPL_UNI  = 2'b00,
        CPL_BI   = 2'b01,
        CPL_QUAD = 2'b10
    } etcu_couple_t;

    typedef enum logic [1:0] {
        MEAS_COUNT = 2'b00,
        MEAS_ANGLE = 2'b01,
        MEAS_FREQ  = 2'b10,
        MEAS_RPM   = 2'b11
    } etcu_meas_t;

    typedef enum logic [1:0] {
        RP_MANUAL = 2'b00,
        RP_START  = 2'b01,
        RP_FIRST  = 2'b10,
        RP_EVERY  = 2'b11
    } etcu_rpol_t;

    typedef enum logic [1:0] {
        O1_TRIG  = 2'b00,
        O1_ALARM = 2'b01,
        O1_HIGH  = 2'b10,
        O1_LOW   = 2'b11
    } etcu_out1_t;

    typedef enum logic [1:0] {
        O2_REC  = 2'b00,
        O2_HIGH = 2'b01,
        O2_LOW  = 2'b10
    } etcu_out2_t;
endpackage

/* hdl/etcu_top.sv */
// etcu_top: event inputs, event outputs and two timer/counter channels with AHB-Lite registers
// Functional notes
// - sixteen event inputs, each with its own software inversion bit
// - two-stage synchronisers at 10 MHz catch 100 ns pulses, 5 MHz toggles
// - output one selects trigger pulse, alarm, forced high or forced low
// - output two selects recording active, forced high or forced low
// - one pulse per local trigger arriving outside a running pulse cycle, 12.8 us wide, 200 us after trigger
// - alarm output follows card alarm delayed by 200 us
// - recording output follows recording state delayed by five clocks, 500 ns
// - forced modes drive a static level written by software
// - two channels, signal reset direction chosen from event pins
// - coupling modes uni-directional, bi-directional, quadrature with index
// - measure count, angle, frequency or rpm from count change and time
// - interval timer counts a 20 MHz time base, two ticks per clock
// - window length in samples, from one up to a programmed count
// - results latch once per window only
// - direction pin used in bi-directional mode, where high counts down, and as phase b in quadrature
// - reset pin polarity selectable by an inversion bit
// - manual policy clears only on software command
// - start policy clears counter when recording starts
// - first-pulse policy: only first reset pulse after start clears
// - every-pulse policy clears counter on each reset pulse
// - angle mode wraps at maximum; reset pulse loads reference angle
// - unsigned 0 to 2^31 for uni, signed 32-bit for bi
`timescale 1ns/1ps
module etcu_top
    import etcu_pkg::*;
#(
    parameter int TRIG_DELAY = TRIG_DELAY_CYC,
    parameter int TRIG_WIDTH = TRIG_WIDTH_CYC
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [7:0]            haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // card status from acquisition logic
    input  wire logic                  trigIn,
    input  wire logic                  alarmIn,
    input  wire logic                  recording,
    // pins
    input  wire logic [NUM_EVENTS-1:0] eventPins,
    output logic                       eventOut1,
    output logic                       eventOut2
);
    localparam int DW = $clog2(TRIG_DELAY + 2);

    typedef struct packed {
        logic [1:0][NUM_EVENTS-1:0] sync;
        logic [NUM_EVENTS-1:0]      inv;
        logic [1:0]                 o1Sel;
        logic [1:0]                 o2Sel;
        logic [DW-1:0]              dlyCnt;   // trigger delay countdown
        logic [DW-1:0]              wCnt;     // pulse width countdown
        logic                       o1;
        logic [REC_DELAY_CYC:0]     recPipe;
        logic [DW-1:0]              alCnt;
        logic                       alOut;
        logic                       recPrev;
        logic                       aSel;
        logic                       aWr;
        logic [7:0]                 aAddr;
        logic [31:0]                rdata;
        logic [NUM_CNT-1:0][31:0]   cfg;
        logic [NUM_CNT-1:0][15:0]   win;
        logic [NUM_CNT-1:0][31:0]   maxc;
        logic [NUM_CNT-1:0][31:0]   refc;
        logic [NUM_CNT-1:0][31:0]   cnt;
        logic [NUM_CNT-1:0][31:0]   cntAtWin;
        logic [NUM_CNT-1:0][31:0]   dCnt;
        logic [NUM_CNT-1:0][31:0]   dT;
        logic [NUM_CNT-1:0][31:0]   tb;
        logic [NUM_CNT-1:0][15:0]   winCnt;
        logic [NUM_CNT-1:0][2:0]    filt;     // filtered sig, rst, dir
        logic [NUM_CNT-1:0][2:0]    filtPrev;
        logic [NUM_CNT-1:0][23:0]   fCnt;     // 8-bit counter per input
        logic [NUM_CNT-1:0]         firstDone;
    } etcu_state_t;

    etcu_state_t s_q;
    etcu_state_t s_d;

    logic [NUM_EVENTS-1:0] evt;
    assign evt       = s_q.sync[1] ^ s_q.inv;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_q.rdata;
    assign eventOut1 = s_q.o1;
    assign eventOut2 = (s_q.o2Sel == O2_REC)  ? s_q.recPipe[REC_DELAY_CYC] :
                       (s_q.o2Sel == O2_HIGH);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [31:0]  rv;
        logic [2:0]   raw;
        logic [1:0]   cp;
        logic         up;
        logic         dn;
        logic         rstEdge;
        logic         clrHit;
        logic         recStart;
        logic [7:0]   flen;
        logic [7:0]   ra;
        int           ch;
        rv       = 32'h0;
        raw      = 3'b000;
        cp       = 2'b00;
        up       = 1'b0;
        dn       = 1'b0;
        rstEdge  = 1'b0;
        clrHit   = 1'b0;
        flen     = 8'h00;
        ra       = 8'h00;
        ch       = 0;
        s_d      = s_q;
        recStart = recording & ~s_q.recPrev;
        // input synchronisers, second stage alone is read
        s_d.sync[0] = eventPins;
        s_d.sync[1] = s_q.sync[0];
        s_d.recPrev = recording;
        s_d.recPipe = {s_q.recPipe[REC_DELAY_CYC-1:0], recording};

        // trigger pulse: a trigger during a running pulse cycle is dropped
        if (trigIn && s_q.dlyCnt == '0 && s_q.wCnt == '0) begin
            s_d.dlyCnt = DW'(TRIG_DELAY);
        end else if (s_q.dlyCnt != '0) begin
            s_d.dlyCnt = s_q.dlyCnt - 1'b1;
            if (s_q.dlyCnt == DW'(1)) begin
                s_d.wCnt = DW'(TRIG_WIDTH);
            end
        end else if (s_q.wCnt != '0) begin
            s_d.wCnt = s_q.wCnt - 1'b1;
        end
        // alarm delay: a level change must persist for the full delay
        if (alarmIn == s_q.alOut) begin
            s_d.alCnt = '0;
        end else if (s_q.alCnt == DW'(TRIG_DELAY - 1)) begin
            s_d.alOut = alarmIn;
            s_d.alCnt = '0;
        end else begin
            s_d.alCnt = s_q.alCnt + 1'b1;
        end
        case (s_q.o1Sel)
            O1_TRIG:  s_d.o1 = (s_d.wCnt != '0);
            O1_ALARM: s_d.o1 = s_d.alOut;
            O1_HIGH:  s_d.o1 = 1'b1;
            default:  s_d.o1 = 1'b0;
        endcase

        // ahb address phase capture
        if (hready) begin
            s_d.aSel  = hsel && htrans[1];
            s_d.aWr   = hwrite;
            s_d.aAddr = haddr;
        end

        // counter channels
        for (ch = 0; ch < NUM_CNT; ch++) begin
            // clear per channel so one channel's step never leaks into the next
            up   = 1'b0;
            dn   = 1'b0;
            cp   = s_q.cfg[ch][CFG_COUPLE_LSB +: 2];
            flen = s_q.cfg[ch][CFG_FILT_LSB +: 8];
            raw  = {evt[s_q.cfg[ch][CFG_DIR_LSB +: 4]],
                    evt[s_q.cfg[ch][CFG_RST_LSB +: 4]] ^ s_q.cfg[ch][CFG_RINV_BIT],
                    evt[s_q.cfg[ch][CFG_SIG_LSB +: 4]]};
            // width filter: new level must hold flen + 1 cycles
            for (int b = 0; b < 3; b++) begin
                if (raw[b] == s_q.filt[ch][b]) begin
                    s_d.fCnt[ch][b*8 +: 8] = 8'h00;
                end else if (s_q.fCnt[ch][b*8 +: 8] >= flen) begin
                    s_d.filt[ch][b] = raw[b];
                    s_d.fCnt[ch][b*8 +: 8] = 8'h00;
                end else begin
                    s_d.fCnt[ch][b*8 +: 8] = s_q.fCnt[ch][b*8 +: 8] + 8'h01;
                end
            end
            s_d.filtPrev[ch] = s_q.filt[ch];
            rstEdge = s_q.filt[ch][1] & ~s_q.filtPrev[ch][1];
            if (cp == CPL_QUAD) begin
                // signal pin is phase a, direction pin is phase b
                case ({s_q.filtPrev[ch][0], s_q.filtPrev[ch][2], s_q.filt[ch][0], s_q.filt[ch][2]})
                    4'b0010, 4'b1011, 4'b1101, 4'b0100: up = 1'b1;
                    4'b0001, 4'b0111, 4'b1110, 4'b1000: dn = 1'b1;
                    default: begin
                        up = 1'b0;
                        dn = 1'b0;
                    end
                endcase
            end else begin
                up = s_q.filt[ch][0] & ~s_q.filtPrev[ch][0];
                dn = 1'b0;
                if (cp == CPL_BI && s_q.filt[ch][2]) begin
                    dn = up;
                    up = 1'b0;
                end
            end
            if (up) begin
                if (s_q.cfg[ch][CFG_MEAS_LSB +: 2] == MEAS_ANGLE &&
                    s_q.cnt[ch] + 32'h1 >= s_q.maxc[ch]) begin
                    s_d.cnt[ch] = 32'h0;
                end else if (cp == CPL_UNI && s_q.cnt[ch] == 32'h8000_0000) begin
                    s_d.cnt[ch] = s_q.cnt[ch];
                end else begin
                    s_d.cnt[ch] = s_q.cnt[ch] + 32'h1;
                end
            end else if (dn) begin
                if (s_q.cfg[ch][CFG_MEAS_LSB +: 2] == MEAS_ANGLE && s_q.cnt[ch] == 32'h0) begin
                    s_d.cnt[ch] = s_q.maxc[ch] - 32'h1;
                end else begin
                    s_d.cnt[ch] = s_q.cnt[ch] - 32'h1;
                end
            end
            if (recStart) begin
                s_d.firstDone[ch] = 1'b0;
            end
            case (s_q.cfg[ch][CFG_RPOL_LSB +: 2])
                RP_START: clrHit = recStart;
                RP_FIRST: begin
                    clrHit = rstEdge && recording && !s_q.firstDone[ch];
                    if (clrHit) begin
                        s_d.firstDone[ch] = 1'b1;
                    end
                end
                RP_EVERY: clrHit = rstEdge;
                default:  clrHit = 1'b0;
            endcase
            if (s_q.aSel && s_q.aWr && s_q.aAddr == REG_CMD &&
                hwdata[CMD_CLR0_BIT + ch]) begin
                clrHit = 1'b1;
            end
            if (clrHit) begin
                s_d.cnt[ch] = (s_q.cfg[ch][CFG_MEAS_LSB +: 2] == MEAS_ANGLE) ?
                              s_q.refc[ch] : 32'h0;
            end
            // time base runs at twice the clock rate
            s_d.tb[ch] = s_q.tb[ch] + 32'(TBASE_HZ / CLK_HZ);
            if (s_q.winCnt[ch] + 16'h1 >= s_q.win[ch]) begin
                s_d.winCnt[ch]   = 16'h0;
                s_d.dCnt[ch]     = s_d.cnt[ch] - s_q.cntAtWin[ch];
                s_d.cntAtWin[ch] = s_d.cnt[ch];
                s_d.dT[ch]       = s_d.tb[ch];
                s_d.tb[ch]       = 32'h0;
            end else begin
                s_d.winCnt[ch] = s_q.winCnt[ch] + 16'h1;
            end
        end

        // ahb data phase writes
        if (s_q.aSel && s_q.aWr) begin
            case (s_q.aAddr)
                REG_EVT_INV:  s_d.inv = hwdata[NUM_EVENTS-1:0];
                REG_OUT_CTRL: begin
                    s_d.o1Sel = hwdata[1:0];
                    s_d.o2Sel = hwdata[5:4];
                end
                default: begin
                    ra = s_q.aAddr - REG_CH0_CFG;
                    if (s_q.aAddr >= REG_CH0_CFG && ra[7:5] < 3'(NUM_CNT)) begin
                        ch = int'(ra[5]);
                        case (ra[4:0])
                            5'h00: s_d.cfg[ch]  = hwdata;
                            5'h04: s_d.win[ch]  = (hwdata[15:0] == 16'h0) ? 16'h1 : hwdata[15:0];
                            5'h08: s_d.maxc[ch] = hwdata;
                            5'h0c: s_d.refc[ch] = hwdata;
                            default: s_d.rdata = s_q.rdata;
                        endcase
                    end
                end
            endcase
        end
        // read mux, data presented one cycle after address phase
        if (hready && hsel && htrans[1] && !hwrite) begin
            ra = haddr - REG_CH0_CFG;
            ch = int'(ra[5]);
            case (haddr)
                REG_EVT_INV:  rv = 32'(s_q.inv);
                REG_EVT_STAT: rv = 32'(evt);
                REG_OUT_CTRL: rv = {26'h0, s_q.o2Sel, 2'b00, s_q.o1Sel};
                default: begin
                    if (haddr >= REG_CH0_CFG && ra[7:6] == 2'b00) begin
                        case (ra[4:0])
                            5'h00: rv = s_q.cfg[ch];
                            5'h04: rv = {16'h0, s_q.win[ch]};
                            5'h08: rv = s_q.maxc[ch];
                            5'h0c: rv = s_q.refc[ch];
                            5'h10: rv = s_q.cnt[ch];
                            5'h14: rv = s_q.dCnt[ch];
                            5'h18: rv = s_q.dT[ch];
                            default: rv = 32'h0;
                        endcase
                    end
                end
            endcase
            s_d.rdata = rv;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q        <= '0;
            s_q.o1Sel  <= O1_LOW;
            s_q.o2Sel  <= O2_LOW;
            s_q.win    <= {16'h1, 16'h1};
            s_q.maxc   <= {32'd360, 32'd360};
        end else begin
            s_q <= s_d;
        end
    end
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence trigSeen;
        trigIn && s_q.dlyCnt == '0 && s_q.wCnt == '0 && s_q.o1Sel == O1_TRIG;
    endsequence

    chk_trig_delay: assert property (s_q.dlyCnt == DW'(1) && s_q.o1Sel == O1_TRIG
        |=> eventOut1) else $error("trigger pulse late");
    chk_trig_quiet: assert property (trigSeen |=> !eventOut1 [*8])
        else $error("trigger pulse early");
    chk_rec_follow: assert property ((s_q.o2Sel == O2_REC) [*5]
        |-> eventOut2 == $past(recording, 5)) else $error("record output lag wrong");
    chk_force_high: assert property (s_q.o1Sel == O1_HIGH |=> eventOut1)
        else $error("forced high not driven");
    chk_force_two: assert property (s_q.o2Sel == O2_LOW |-> !eventOut2)
        else $error("forced low not driven");
    chk_evt_inv: assert property (##2 evt == ($past(eventPins, 2) ^ s_q.inv) ||
        !$stable(s_q.inv)) else $error("event inversion wrong");
    chk_every_clr: assert property (s_q.cfg[0][CFG_RPOL_LSB +: 2] == RP_EVERY &&
        s_q.cfg[0][CFG_MEAS_LSB +: 2] == MEAS_COUNT && s_q.filt[0][1] && !s_q.filtPrev[0][1]
        |=> s_q.cnt[0] == 32'h0) else $error("reset pulse did not clear");
    chk_start_clr: assert property (s_q.cfg[0][CFG_RPOL_LSB +: 2] == RP_START &&
        s_q.cfg[0][CFG_MEAS_LSB +: 2] == MEAS_COUNT && recording && !s_q.recPrev
        |=> s_q.cnt[0] == 32'h0) else $error("start did not clear");
    chk_angle_max: assert property (s_q.cfg[0][CFG_MEAS_LSB +: 2] == MEAS_ANGLE &&
        s_q.maxc[0] != 32'h0 |-> s_q.cnt[0] < s_q.maxc[0] || !$stable(s_q.maxc[0]) ||
        $past(s_q.cfg[0][CFG_MEAS_LSB +: 2]) != MEAS_ANGLE || s_q.cnt[0] == s_q.refc[0])
        else $error("angle exceeds maximum");
endmodule

/* sim/etcu_src_model.sv */
// etcu_src_model: encoder and ttl pulse source on the event pins
`timescale 1ns/1ps
module etcu_src_model (
    // clock
    input  wire logic        clk,
    // event pins toward the card
    output logic      [15:0] pins
);
    // ************************************************************
    // stimulus tasks
    // ************************************************************
    initial pins = 16'h0000;
    // static level on every pin
    task automatic put(input logic [15:0] v);
        @(posedge clk);
        pins <= v;
    endtask
    // n pulses, w cycles high and w low; direction pin is never moved here
    task automatic pulse(input int p, input int n, input int w);
        for (int i = 0; i < 2 * n; i++) begin
            repeat (w) @(posedge clk);
            pins[p] <= ~pins[p];
        end
        repeat (6) @(posedge clk);
    endtask
    // gray steps on pins 0 and 1; slow enough to pass sync and filter
    task automatic quad(input int n, input logic up);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            if ((pins[0] == pins[1]) == up)
                pins[0] <= ~pins[0];
            else
                pins[1] <= ~pins[1];
        end
        repeat (6) @(posedge clk);
    endtask
endmodule

/* sim/etcu_top_tb.sv */
// etcu_top_tb: self-checking bench for the event timer counter unit
`timescale 1ns/1ps
module etcu_top_tb;
    import etcu_pkg::*;
    localparam int TD = 20;
    localparam int TW = 4;
    logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic        trigIn, alarmIn, recording, eventOut1, eventOut2;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [15:0] eventPins, v, iv;
    int          n_errors, tests_run, k, n;
    integer      seed;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    etcu_top #(.TRIG_DELAY(TD), .TRIG_WIDTH(TW)) dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .trigIn(trigIn), .alarmIn(alarmIn), .recording(recording), .eventPins(eventPins),
        .eventOut1(eventOut1), .eventOut2(eventOut2));
    etcu_src_model src (.clk(clk), .pins(eventPins));

    // 10 mhz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic chkIn(input string nm, input int lo, input int hi);
        tests_run++;
        if (k < lo || k > hi) begin
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, k);
            n_errors++;
        end
    endtask
    // bounded wait, counting edges into k until the output reaches l
    task automatic waitOut(input logic w, input logic l, input int lim);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while ((w ? eventOut2 : eventOut1) !== l && k < lim);
        if (k >= lim) begin
            n_errors++;
            end_of_test;
        end
    endtask
    // address phase then data phase, each held until ready is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        do begin
            @(posedge clk);
            t++;
        end while (hready !== 1'b1 && t < 50);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge clk);
            t++;
        end while (hready !== 1'b1 && t < 100);
        rd = hrdata;
        chk("hreadyout hresp", 32'h2, {30'h0, hreadyout, hresp});
        if (t >= 100) begin
            n_errors++;
            end_of_test;
        end
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // channel config, signal pin 2, reset pin 3, direction pin 4
    function automatic logic [31:0] cfg(input etcu_couple_t c, input etcu_rpol_t p,
                                        input logic [7:0] f);
        return {8'h04, 4'h3, 4'h2, f, 2'b00, p, 2'b00, c};
    endfunction

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        seed = 32'ha75fe60b;
        {n_errors, tests_run, k} = '0;
        {rst, hsel, hwrite, trigIn, alarmIn, recording} = 6'b100000;
        {haddr, htrans, hsize, hwdata} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc("outCtrl", REG_OUT_CTRL, 32'h23);
        chk("out", 32'h0, {30'h0, eventOut1, eventOut2});
        rdc("unmapped", 8'hfc, 32'h0);
        for (int i = 0; i < 8; i++) begin
            v  = 16'($random(seed));
            iv = 16'($random(seed));
            bus(1'b1, REG_EVT_INV, {16'h0, iv});
            src.put(v);
            repeat (4) @(posedge clk);
            rdc("evtStat", REG_EVT_STAT, {16'h0, v ^ iv});
        end
        bus(1'b1, REG_EVT_INV, 32'h0);
        src.put(16'h0000);
        $display("test reset and events done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, REG_OUT_CTRL, {26'h0, i[1] ? O2_LOW : O2_HIGH, 2'b00,
                i[0] ? O1_LOW : O1_HIGH});
            repeat (2) @(posedge clk);
            chk("forced", {30'h0, ~i[0], ~i[1]}, {30'h0, eventOut1, eventOut2});
        end
        bus(1'b1, REG_OUT_CTRL, 32'h0);
        recording <= 1'b1;
        waitOut(1'b1, 1'b1, 20);
        chkIn("recDelay", REC_DELAY_CYC, REC_DELAY_CYC + 1);
        recording <= 1'b0;
        trigIn <= 1'b1;
        @(posedge clk);
        trigIn <= 1'b0;
        waitOut(1'b0, 1'b1, 100);
        chkIn("trigDelay", TD - 1, TD + 1);
        waitOut(1'b0, 1'b0, 100);
        chkIn("trigWidth", TW, TW);
        bus(1'b1, REG_OUT_CTRL, 32'h1);
        alarmIn <= 1'b1;
        waitOut(1'b0, 1'b1, 2100);
        chkIn("alarmOn", TD - 1, TD + 1);
        alarmIn <= 1'b0;
        waitOut(1'b0, 1'b0, 2100);
        chkIn("alarmOff", TD - 1, TD + 1);
        $display("test outputs done");
        n = {$random(seed)} % 6 + 2;
        bus(1'b1, REG_CH0_CFG, cfg(CPL_UNI, RP_MANUAL, 8'h00));
        bus(1'b1, REG_CMD, 32'h1);
        src.pulse(2, n, 3);
        rdc("cntUni", REG_CH0_CNT, n);
        src.pulse(3, 1, 3);
        rdc("manualHold", REG_CH0_CNT, n);
        bus(1'b1, REG_CMD, 32'h1);
        rdc("manualClr", REG_CH0_CNT, 32'h0);
        bus(1'b1, REG_CH0_CFG, cfg(CPL_BI, RP_MANUAL, 8'h00));
        src.put(16'h0010);
        src.pulse(2, 3, 3);
        rdc("cntDown", REG_CH0_CNT, 32'hfffffffd);
        bus(1'b1, REG_CH0_CFG, cfg(CPL_UNI, RP_MANUAL, 8'h00));
        bus(1'b1, REG_CMD, 32'h1);
        src.pulse(2, 2, 3);
        rdc("uniIgnoresDir", REG_CH0_CNT, 32'h2);
        src.put(16'h0000);
        bus(1'b1, REG_CH0_CFG, cfg(CPL_UNI, RP_EVERY, 8'h00));
        src.pulse(3, 1, 3);
        rdc("everyPulse", REG_CH0_CNT, 32'h0);
        bus(1'b1, REG_CH0_CFG, cfg(CPL_UNI, RP_START, 8'h00));
        src.pulse(2, 3, 3);
        recording <= 1'b1;
        repeat (4) @(posedge clk);
        rdc("startRec", REG_CH0_CNT, 32'h0);
        bus(1'b1, REG_CH0_CFG, cfg(CPL_UNI, RP_FIRST, 8'h00));
        recording <= 1'b0;
        repeat (2) @(posedge clk);
        recording <= 1'b1;
        src.pulse(2, 2, 3);
        src.pulse(3, 1, 3);
        rdc("firstPulse", REG_CH0_CNT, 32'h0);
        src.pulse(2, 3, 3);
        src.pulse(3, 1, 3);
        rdc("laterIgnored", REG_CH0_CNT, 32'h3);
        bus(1'b1, REG_CH0_CFG, cfg(CPL_UNI, RP_MANUAL, 8'h06));
        bus(1'b1, REG_CMD, 32'h1);
        src.pulse(2, 3, 2);
        rdc("filtShort", REG_CH0_CNT, 32'h0);
        src.pulse(2, 1, 10);
        rdc("filtLong", REG_CH0_CNT, 32'h1);
        bus(1'b1, REG_CH0_MAX, 32'h3);
        bus(1'b1, REG_CH0_CFG, cfg(CPL_UNI, RP_MANUAL, 8'h00) | 32'h4);
        bus(1'b1, REG_CMD, 32'h1);
        src.pulse(2, 4, 3);
        rdc("angleWrap", REG_CH0_CNT, 32'h1);
        bus(1'b1, REG_CH0_CFG + CH_STRIDE, 32'h01300002);
        bus(1'b1, REG_CMD, 32'h2);
        src.quad(8, 1'b1);
        rdc("quadUp", REG_CH0_CNT + CH_STRIDE, 32'h8);
        src.quad(3, 1'b0);
        rdc("quadDown", REG_CH0_CNT + CH_STRIDE, 32'h5);
        bus(1'b1, REG_CH0_WIN, 32'h0);
        rdc("winMin", REG_CH0_WIN, 32'h1);
        bus(1'b1, REG_CH0_WIN, 32'ha);
        repeat (30) @(posedge clk);
        rdc("deltaTime", REG_CH0_DT, 32'h14);
        $display("test counters done");
        end_of_test;
    end
endmodule
